// ===== core/mcs_current_ramp.sv
// Purpose: Coil current scale selection and run/hold ramping with standstill detect
// Assumes: Step pin is asynchronous; table values and load-adaptive scale are on clock
// Notes: Long counts are parameters so simulation can shorten them
`timescale 1ns/10ps
`default_nettype none
module mcs_current_ramp
   import mcs_pkg::*;
#(
   parameter int STST_CYC = MCS_STST_CYC,
   parameter int HOLD_STEP_CYC = MCS_HOLD_STEP_CYC,
   parameter int PD_UNIT_CYC = MCS_PD_UNIT_CYC
)
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic step_pin,
   input wire logic signed [8:0] coil_a_table,
   input wire logic signed [8:0] coil_b_table,
   input wire logic [4:0] load_adapt_scale,
   output logic signed [8:0] coil_a_out,
   output logic signed [8:0] coil_b_out,
   output logic standstill,
   output logic [4:0] actual_scale,
   output logic [1:0] full_scale_range,
   output logic ext_range
);

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   logic [4:0] run_current_scale_q;
   logic [4:0] hold_current_scale_q;
   logic [3:0] hold_ramp_delay_q;
   logic [3:0] run_ramp_delay_q;
   logic [7:0] power_down_delay_q;
   logic [1:0] driver_config_q;
   logic load_adapt_en_q;
   logic [31:0] rdata_q;
   logic standstill_q;
   logic [4:0] scale_q;

   wire logic wr_cur = wr && (addr == MCS_OFS_CURRENT);
   wire logic wr_pdd = wr && (addr == MCS_OFS_PDOWN);
   wire logic wr_drv = wr && (addr == MCS_OFS_DRVCONF);

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         run_current_scale_q <= MCS_RST_RUN;
         hold_current_scale_q <= MCS_RST_HOLD;
         hold_ramp_delay_q <= MCS_RST_HDLY;
         run_ramp_delay_q <= MCS_RST_RDLY;
         power_down_delay_q <= MCS_RST_PDD;
         driver_config_q <= MCS_RST_FSR;
         load_adapt_en_q <= 1'b0;
      end
      else if (ce)
      begin
         if (wr_cur)
         begin
            run_current_scale_q <= wdata[MCS_POS_RUN +: 5];
            hold_current_scale_q <= wdata[MCS_POS_HOLD +: 5];
            hold_ramp_delay_q <= wdata[MCS_POS_HDLY +: 4];
            run_ramp_delay_q <= wdata[MCS_POS_RDLY +: 4];
         end
         if (wr_pdd)
            power_down_delay_q <= wdata[MCS_POS_PDD +: 8];
         if (wr_drv)
         begin
            driver_config_q <= wdata[MCS_POS_FSR +: 2];
            load_adapt_en_q <= wdata[MCS_POS_LAEN];
         end
      end
   end

   // Unmapped offsets read as zero
   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      case (addr)
         MCS_OFS_CURRENT:
         begin
            rd_mux[MCS_POS_RUN +: 5] = run_current_scale_q;
            rd_mux[MCS_POS_HOLD +: 5] = hold_current_scale_q;
            rd_mux[MCS_POS_HDLY +: 4] = hold_ramp_delay_q;
            rd_mux[MCS_POS_RDLY +: 4] = run_ramp_delay_q;
         end
         MCS_OFS_PDOWN: rd_mux[MCS_POS_PDD +: 8] = power_down_delay_q;
         MCS_OFS_DRVCONF:
         begin
            rd_mux[MCS_POS_FSR +: 2] = driver_config_q;
            rd_mux[MCS_POS_LAEN] = load_adapt_en_q;
         end
         MCS_OFS_STATUS:
         begin
            rd_mux[MCS_POS_STST] = standstill_q;
            rd_mux[MCS_POS_ACT +: 5] = scale_q;
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         rdata_q <= 32'h0000_0000;
      else if (ce)
         rdata_q <= rd ? rd_mux : 32'h0000_0000;
   end

   assign rdata = rdata_q;

   // ----------------------------------------
   // Step input sync and standstill detect
   // ----------------------------------------
   logic step_s1_q;
   logic step_s2_q;
   logic step_s3_q;
   logic [20:0] stst_cnt_q;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         step_s1_q <= 1'b0;
         step_s2_q <= 1'b0;
         step_s3_q <= 1'b0;
      end
      else if (ce)
      begin
         step_s1_q <= step_pin;
         step_s2_q <= step_s1_q;
         step_s3_q <= step_s2_q;
      end
   end

   wire logic step_edge = step_s2_q && !step_s3_q;
   wire logic stst_reach = (stst_cnt_q == 21'(STST_CYC - 1));

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         stst_cnt_q <= 21'h000000;
         standstill_q <= 1'b0;
      end
      else if (ce)
      begin
         if (step_edge)
         begin
            stst_cnt_q <= 21'h000000;
            standstill_q <= 1'b0;
         end
         else if (!standstill_q)
         begin
            stst_cnt_q <= stst_cnt_q + 21'h000001;
            standstill_q <= stst_reach;
         end
      end
   end

   // ----------------------------------------
   // Scale ramp state machine
   // ----------------------------------------
   mcs_state_t state_q;
   mcs_state_t state_d;
   logic [4:0] scale_d;
   logic [26:0] timer_q;
   logic [26:0] timer_d;

   // Load-adaptive reduction may lower the current but never exceed run
   wire logic [4:0] run_tgt = (load_adapt_en_q && load_adapt_scale < run_current_scale_q) ?
      load_adapt_scale : run_current_scale_q;
   wire logic [26:0] pd_tgt = (power_down_delay_q < 8'h02) ? 27'(power_down_delay_q) :
      27'(int'(power_down_delay_q) * PD_UNIT_CYC);
   wire logic [26:0] hold_tgt = 27'(int'(hold_ramp_delay_q) * HOLD_STEP_CYC - 1);
   wire logic [26:0] run_tgt_cyc = 27'(int'(run_ramp_delay_q) * MCS_RUN_STEP_CYC - 1);
   wire logic zw_done = (timer_q >= pd_tgt);
   wire logic hold_tick = (timer_q >= hold_tgt);
   wire logic run_tick = (timer_q >= run_tgt_cyc);
   wire logic timer_inc = (state_q == MCS_ZWAIT && standstill_q) || (state_q == MCS_HRAMP) ||
      (state_q == MCS_RRAMP);
   wire logic run_short = (scale_q < run_tgt) && (run_ramp_delay_q != 4'h0);

   always_comb
   begin
      state_d = state_q;
      scale_d = scale_q;
      timer_d = timer_inc ? timer_q + 27'h0000001 : 27'h0000000;
      case (state_q)
         MCS_RUN:
         begin
            scale_d = run_tgt;
            if (standstill_q)
            begin
               state_d = MCS_ZWAIT;
               timer_d = 27'h0000000;
            end
         end
         MCS_ZWAIT:
         begin
            if (!standstill_q)
               state_d = run_short ? MCS_RRAMP : MCS_RUN;
            else if (zw_done)
            begin
               timer_d = 27'h0000000;
               if (hold_ramp_delay_q == 4'h0)
               begin
                  scale_d = hold_current_scale_q;
                  state_d = MCS_HOLD;
               end
               else
                  state_d = MCS_HRAMP;
            end
         end
         MCS_HRAMP:
         begin
            if (!standstill_q)
            begin
               state_d = MCS_RRAMP;
               timer_d = 27'h0000000;
            end
            else if (scale_q <= hold_current_scale_q || hold_ramp_delay_q == 4'h0)
            begin
               scale_d = hold_current_scale_q;
               state_d = MCS_HOLD;
            end
            else if (hold_tick)
            begin
               scale_d = scale_q - 5'h01;
               timer_d = 27'h0000000;
            end
         end
         MCS_HOLD:
         begin
            scale_d = hold_current_scale_q;
            if (!standstill_q)
            begin
               timer_d = 27'h0000000;
               if (run_ramp_delay_q == 4'h0)
               begin
                  scale_d = run_tgt;
                  state_d = MCS_RUN;
               end
               else
                  state_d = MCS_RRAMP;
            end
         end
         MCS_RRAMP:
         begin
            if (standstill_q)
            begin
               state_d = MCS_ZWAIT;
               timer_d = 27'h0000000;
            end
            else if (scale_q >= run_tgt || run_ramp_delay_q == 4'h0)
            begin
               scale_d = run_tgt;
               state_d = MCS_RUN;
            end
            else if (run_tick)
            begin
               scale_d = scale_q + 5'h01;
               timer_d = 27'h0000000;
            end
         end
         default:
         begin
            state_d = MCS_RUN;
            timer_d = 27'h0000000;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q <= MCS_RUN;
         scale_q <= MCS_RST_RUN;
         timer_q <= 27'h0000000;
      end
      else if (ce)
      begin
         state_q <= state_d;
         scale_q <= scale_d;
         timer_q <= timer_d;
      end
   end

   // ----------------------------------------
   // Coil scalers and outputs
   // ----------------------------------------
   logic signed [8:0] coil_tab [2];
   logic signed [8:0] coil_res [2];
   assign coil_tab[0] = coil_a_table;
   assign coil_tab[1] = coil_b_table;

   for (genvar c = 0; c < 2; c++)
   begin : g_coil
      mcs_coil_if cif ();
      assign cif.table_val = coil_tab[c];
      assign cif.scale = scale_q;
      assign coil_res[c] = cif.scaled;
      mcs_coil_scaler u_scaler (
         .clock(clock),
         .rstn(rstn),
         .ce(ce),
         .cif(cif)
      );
   end

   assign coil_a_out = coil_res[0];
   assign coil_b_out = coil_res[1];
   assign standstill = standstill_q;
   assign actual_scale = scale_q;
   assign full_scale_range = driver_config_q;
   // 10 and 11 share the 3A range; only 11 widens the operating range
   assign ext_range = (driver_config_q == MCS_FSR_EXT3A);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_stst_clear: assert property (@(posedge clock) disable iff (!rstn)
      (ce && step_edge) |=> !standstill_q)
      else $error("Standstill not cleared by step");
   a_stst_set_time: assert property (@(posedge clock) disable iff (!rstn)
      $rose(standstill_q) |-> $past(stst_cnt_q) == 21'(STST_CYC - 1))
      else $error("Standstill set at wrong count");
   a_run_tracks: assert property (@(posedge clock) disable iff (!rstn)
      (ce && state_q == MCS_RUN && !standstill_q) |=> scale_q == $past(run_tgt))
      else $error("Run scale not applied");
   a_run_cap: assert property (@(posedge clock) disable iff (!rstn)
      (state_q == MCS_RUN && $past(state_q) == MCS_RUN) |-> scale_q <= run_current_scale_q
      || $past(wr_cur))
      else $error("Scale above run limit");
   a_hold_instant: assert property (@(posedge clock) disable iff (!rstn)
      (ce && state_q == MCS_ZWAIT && standstill_q && zw_done && hold_ramp_delay_q == 4'h0)
      |=> state_q == MCS_HOLD && scale_q == $past(hold_current_scale_q))
      else $error("Zero hold delay not instant");
   a_hold_step: assert property (@(posedge clock) disable iff (!rstn)
      (state_q == MCS_HRAMP && $past(state_q) == MCS_HRAMP) |->
      (scale_q == $past(scale_q) || scale_q + 5'h01 == $past(scale_q)))
      else $error("Down ramp moved more than one step");
   a_zwait_first: assert property (@(posedge clock) disable iff (!rstn)
      (state_q == MCS_HRAMP && $past(state_q) == MCS_ZWAIT) |-> $past(zw_done))
      else $error("Down ramp started before zero wait");
   a_run_instant: assert property (@(posedge clock) disable iff (!rstn)
      (ce && state_q == MCS_HOLD && !standstill_q && run_ramp_delay_q == 4'h0)
      |=> state_q == MCS_RUN)
      else $error("Zero run delay not instant");
   a_ramp_abort: assert property (@(posedge clock) disable iff (!rstn)
      (ce && state_q == MCS_HRAMP && !standstill_q)
      |=> state_q == MCS_RRAMP && scale_q == $past(scale_q))
      else $error("Down ramp not reversed in place");
   a_range_ext: assert property (@(posedge clock) disable iff (!rstn)
      (ce && wr_drv) |=> ext_range == ($past(wdata[MCS_POS_FSR +: 2]) == MCS_FSR_EXT3A))
      else $error("Extended range does not follow setting 11");

   c_hold_reached: cover property (@(posedge clock) disable iff (!rstn)
      state_q == MCS_HRAMP ##1 state_q == MCS_HOLD);
   c_ramp_abort: cover property (@(posedge clock) disable iff (!rstn)
      state_q == MCS_HRAMP ##1 state_q == MCS_RRAMP);
   c_run_back: cover property (@(posedge clock) disable iff (!rstn)
      state_q == MCS_RRAMP ##1 state_q == MCS_RUN);

endmodule : mcs_current_ramp
`default_nettype wire

// ===== core/mcs_pkg.sv
// Purpose: Shared constants and types for the coil current scale and ramp block
// Assumes: 125 MHz clock, registers reached over a plain strobe port
// Notes: Offsets are byte addresses of 32-bit words
package mcs_pkg;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [3:0] MCS_OFS_CURRENT = 4'h0;
   localparam logic [3:0] MCS_OFS_PDOWN = 4'h4;
   localparam logic [3:0] MCS_OFS_DRVCONF = 4'h8;
   localparam logic [3:0] MCS_OFS_STATUS = 4'hC;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int MCS_POS_RUN = 0;
   localparam int MCS_POS_HOLD = 8;
   localparam int MCS_POS_HDLY = 16;
   localparam int MCS_POS_RDLY = 24;
   localparam int MCS_POS_PDD = 0;
   localparam int MCS_POS_FSR = 0;
   localparam int MCS_POS_LAEN = 8;
   localparam int MCS_POS_STST = 0;
   localparam int MCS_POS_ACT = 8;

   // ----------------------------------------
   // Reset values and the extended 3A range setting
   // ----------------------------------------
   localparam logic [4:0] MCS_RST_RUN = 5'h1F;
   localparam logic [4:0] MCS_RST_HOLD = 5'h10;
   localparam logic [3:0] MCS_RST_HDLY = 4'h1;
   localparam logic [3:0] MCS_RST_RDLY = 4'h4;
   localparam logic [7:0] MCS_RST_PDD = 8'h0A;
   localparam logic [1:0] MCS_RST_FSR = 2'h0;
   localparam logic [1:0] MCS_FSR_EXT3A = 2'h3;

   // ----------------------------------------
   // Timing counts, in clock cycles
   // ----------------------------------------
   localparam int MCS_STST_CYC = 2 ** 20;
   localparam int MCS_HOLD_STEP_CYC = 2 ** 18;
   localparam int MCS_PD_UNIT_CYC = 2 ** 18;
   localparam int MCS_RUN_STEP_CYC = 512;

   typedef enum logic [2:0]
   {
      MCS_RUN = 3'h0,
      MCS_ZWAIT = 3'h1,
      MCS_HRAMP = 3'h3,
      MCS_HOLD = 3'h2,
      MCS_RRAMP = 3'h6
   } mcs_state_t;

endpackage : mcs_pkg

// ===== core/mcs_coil_if.sv
// Purpose: Carrier between the ramp core and one coil scaler
// Assumes: Same clock on both sides
// Notes: One instance per coil
`timescale 1ns/10ps
`default_nettype none
interface mcs_coil_if;
   logic signed [8:0] table_val;
   logic [4:0] scale;
   logic signed [8:0] scaled;
   modport core (output table_val, output scale, input scaled);
   modport scaler (input table_val, input scale, output scaled);
endinterface : mcs_coil_if
`default_nettype wire

// ===== core/mcs_coil_scaler.sv
// Purpose: Scales one sine table value by (scale+1)/32
// Assumes: Table value and scale come from the same clock domain
// Notes: Result is registered; truncation is an arithmetic right shift
`timescale 1ns/10ps
`default_nettype none
module mcs_coil_scaler
   import mcs_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic ce,
   mcs_coil_if.scaler cif
);

   wire logic signed [6:0] factor = $signed({2'h0, cif.scale} + 7'h01);
   wire logic signed [15:0] product = cif.table_val * factor;
   logic signed [8:0] scaled_q;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         scaled_q <= 9'sh000;
      else if (ce)
         scaled_q <= product[13:5];
   end

   assign cif.scaled = scaled_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_full_factor: assert property (@(posedge clock) disable iff (!rstn)
      (ce && cif.scale == 5'h1F) |=> scaled_q == $past(cif.table_val))
      else $error("Full scale factor does not pass table value");
   a_min_factor: assert property (@(posedge clock) disable iff (!rstn)
      (ce && cif.scale == 5'h00) |=> scaled_q == ($past(cif.table_val) >>> 5))
      else $error("Scale zero is not one thirty-second");

endmodule : mcs_coil_scaler
`default_nettype wire

// ===== verif/mcs_step_src.sv
// Purpose: Step pulse source standing in front of the step pin
// Assumes: Bench sets the half period, 2 clocks or more
// Notes: Pin rests low while stopped so standstill can be reached
`timescale 1ns/10ps
`default_nettype none
module mcs_step_src
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic run,
   input wire logic [7:0] half,
   output logic step_pin
);
   // ----------------------------------------
   // Pulse generator
   // ----------------------------------------
   // Shorter phases than 2 clocks could be lost in the pin synchroniser
   logic [7:0] cnt_q;
   logic wrap;
   assign wrap = (cnt_q + 8'h01) >= half;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt_q <= 8'h00;
         step_pin <= 1'b0;
      end
      else if (!run)
      begin
         cnt_q <= 8'h00;
         step_pin <= 1'b0;
      end
      else if (wrap)
      begin
         cnt_q <= 8'h00;
         step_pin <= ~step_pin;
      end
      else
         cnt_q <= cnt_q + 8'h01;
   end
endmodule : mcs_step_src
`default_nettype wire

// ===== verif/tb_top.sv
// Purpose: Self-checking bench for the coil current scale and ramp block
// Assumes: Standstill and hold counts shortened through parameters
// Notes: Register bus driven by tasks; steps come from the step source model
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import mcs_pkg::*;
;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   localparam int STST = 64;
   localparam int HSTEP = 8;
   localparam int PDU = 8;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic ce = 1'b1;
   logic step_run = 1'b0;
   logic [7:0] half = 8'h02;
   logic signed [8:0] ta = 9'h000;
   logic signed [8:0] tb = 9'h000;
   logic [4:0] las = 5'h00;
   logic pin_d = 1'b0;
   logic [31:0] rdata, rv;
   logic signed [8:0] oa, ob;
   logic standstill, ext_range, step_pin;
   logic [4:0] actual_scale, s;
   logic [1:0] fsr;
   int errors = 0;
   int n_tests = 0;
   int seed = 32'h749FBCE3;
   int cyc = 0;
   int last_rise = 0;
   int n, i;

   always #4 clock = ~clock;

   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      pin_d <= step_pin;
      if (step_pin && !pin_d)
         last_rise <= cyc;
   end

   mcs_current_ramp #(.STST_CYC(STST), .HOLD_STEP_CYC(HSTEP), .PD_UNIT_CYC(PDU))
   mcs_current_ramp_inst (.clock(clock), .rstn(rstn), .ce(ce), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .step_pin(step_pin),
      .coil_a_table(ta), .coil_b_table(tb), .load_adapt_scale(las), .coil_a_out(oa),
      .coil_b_out(ob), .standstill(standstill), .actual_scale(actual_scale),
      .full_scale_range(fsr), .ext_range(ext_range));

   mcs_step_src mcs_step_src_inst (.clock(clock), .rstn(rstn), .run(step_run),
      .half(half), .step_pin(step_pin));

   // ----------------------------------------
   // Expectations and helpers
   // ----------------------------------------
   function automatic logic [8:0] f_coil(input logic signed [8:0] t, input logic [4:0] sc);
      logic signed [15:0] p;
      p = 16'(t) * $signed({11'h000, sc} + 16'h0001);
      return p[13:5];
   endfunction : f_coil

   function automatic logic [31:0] f_cur(input logic [4:0] r, input logic [4:0] h,
                                         input logic [3:0] hd, input logic [3:0] rdl);
      return {4'h0, rdl, 4'h0, hd, 3'h0, h, 3'h0, r};
   endfunction : f_cur

   task automatic end_of_test;
      if (errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic cyc_wait(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask : cyc_wait

   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : reg_rd

   task automatic wait_scale(input logic [4:0] tg, input int lim, output int t);
      t = 0;
      while (actual_scale !== tg && t < lim)
      begin
         cyc_wait(1);
         t++;
      end
   endtask : wait_scale

   task automatic wait_st(input logic v, input int lim, output int t);
      t = 0;
      while (standstill !== v && t < lim)
      begin
         cyc_wait(1);
         t++;
      end
   endtask : wait_st

   task automatic coil_chk(input logic [4:0] sc);
      cyc_wait(3);
      chk("coil a", {23'h0, f_coil(ta, sc)}, {23'h0, oa});
      chk("coil b", {23'h0, f_coil(tb, sc)}, {23'h0, ob});
   endtask : coil_chk

   task automatic ramp_watch(input logic [4:0] tg, input int per, input logic [4:0] dir,
                             input int lim);
      int t;
      int last;
      logic [4:0] pv;
      t = 0;
      last = -1;
      pv = actual_scale;
      while (actual_scale !== tg && t < lim)
      begin
         cyc_wait(1);
         t++;
         if (actual_scale !== pv)
         begin
            chk("ramp step", {27'h0, 5'(pv + dir)}, {27'h0, actual_scale});
            if (last >= 0)
               chk("ramp interval", per, t - last);
            last = t;
            pv = actual_scale;
         end
      end
      chk("ramp end", {27'h0, tg}, {27'h0, actual_scale});
   endtask : ramp_watch

   // ----------------------------------------
   // Watchdog
   // ----------------------------------------
   initial
   begin
      repeat (40000) @(posedge clock);
      errors++;
      end_of_test();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (6) @(posedge clock);
      rstn <= 1'b1;
      step_run <= 1'b1;
      cyc_wait(1);
      chk("range at reset", 32'h0, {29'h0, ext_range, fsr});
      reg_rd(MCS_OFS_CURRENT, rv);
      chk("current reset", 32'h0401101F, rv);
      reg_rd(MCS_OFS_PDOWN, rv);
      chk("pdown reset", 32'h0000000A, rv);
      reg_rd(4'h2, rv);
      chk("unmapped read", 32'h0, rv);
      for (i = 0; i < 4; i++)
      begin
         reg_wr(MCS_OFS_DRVCONF, 32'(i));
         cyc_wait(1);
         chk("range field", 32'(i), {30'h0, fsr});
         chk("extended range", {31'h0, i == 3}, {31'h0, ext_range});
         reg_rd(MCS_OFS_DRVCONF, rv);
         chk("range readback", 32'(i), rv);
      end
      for (i = 0; i < 12; i++)
      begin
         s = (i < 2) ? 5'(i * 31) : 5'($random(seed));
         ta <= (i < 2) ? 9'sh100 : 9'($random(seed));
         tb <= (i < 2) ? 9'sd255 : 9'($random(seed));
         half <= 8'(2 + i % 8);
         reg_wr(MCS_OFS_CURRENT, f_cur(s, 5'h10, 4'h1, 4'h1));
         cyc_wait(2);
         chk("run scale", {27'h0, s}, {27'h0, actual_scale});
         coil_chk(s);
      end
      reg_wr(MCS_OFS_DRVCONF, 32'h00000100);
      reg_wr(MCS_OFS_CURRENT, f_cur(5'h14, 5'h10, 4'h1, 4'h1));
      las <= 5'h03;
      cyc_wait(3);
      chk("capped scale", 32'h03, {27'h0, actual_scale});
      las <= 5'h1F;
      cyc_wait(3);
      chk("capped scale", 32'h14, {27'h0, actual_scale});
      reg_wr(MCS_OFS_STATUS, 32'hFFFFFFFF);
      reg_rd(MCS_OFS_STATUS, rv);
      chk("status moving", 32'h00001400, rv);
      // Instant drop to hold, then instant return to run
      reg_wr(MCS_OFS_CURRENT, f_cur(5'h1F, 5'h05, 4'h0, 4'h0));
      reg_wr(MCS_OFS_PDOWN, 32'h1);
      step_run <= 1'b0;
      wait_st(1'b1, STST + 40, n);
      n = cyc - last_rise;
      chk("standstill delay", 32'h1, {31'h0, n >= STST && n <= STST + 6});
      wait_scale(5'h05, 6, n);
      chk("one clock wait", 32'h3, n);
      chk("instant hold", 32'h05, {27'h0, actual_scale});
      ta <= 9'h0C3;
      coil_chk(5'h05);
      reg_rd(MCS_OFS_STATUS, rv);
      chk("status hold", 32'h00000501, rv);
      step_run <= 1'b1;
      wait_st(1'b0, 12, n);
      chk("standstill clear", 32'h0, {31'h0, standstill});
      wait_scale(5'h1F, 4, n);
      chk("instant run", 32'h1F, {27'h0, actual_scale});
      // Clock enable low freezes the scale and drops register writes
      ce <= 1'b0;
      las <= 5'h03;
      reg_wr(MCS_OFS_CURRENT, f_cur(5'h03, 5'h03, 4'h0, 4'h0));
      cyc_wait(2);
      chk("frozen scale", 32'h1F, {27'h0, actual_scale});
      las <= 5'h1F;
      ce <= 1'b1;
      reg_rd(MCS_OFS_CURRENT, rv);
      chk("frozen write", 32'h0000051F, rv);
      // Stepped ramps down and up
      reg_wr(MCS_OFS_CURRENT, f_cur(5'h1F, 5'h10, 4'h1, 4'h1));
      reg_wr(MCS_OFS_PDOWN, 32'h2);
      step_run <= 1'b0;
      wait_st(1'b1, STST + 40, n);
      wait_scale(5'h1E, 60, n);
      chk("zero wait", 32'h1, {31'h0, n >= 2 * PDU && n <= 2 * PDU + HSTEP + 4});
      ramp_watch(5'h10, HSTEP, 5'h1F, 200);
      step_run <= 1'b1;
      ramp_watch(5'h1F, 512, 5'h01, 8200);
      // Motion resumes in the middle of a down ramp
      reg_wr(MCS_OFS_CURRENT, f_cur(5'h1F, 5'h10, 4'h2, 4'h1));
      reg_wr(MCS_OFS_PDOWN, 32'h0);
      step_run <= 1'b0;
      wait_st(1'b1, STST + 40, n);
      wait_scale(5'h1C, 200, n);
      step_run <= 1'b1;
      wait_st(1'b0, 12, n);
      ramp_watch(5'h1F, 512, 5'h01, 3000);
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
